// >>> verilog/ods_pkg.sv
// Purpose: Shared constants for the opcode decode slice.
// Assumes: 8-bit data, 16-bit addresses, binary arithmetic only.
// Notes:   Opcode values, status bit positions and reset values.
package ods_pkg;
    // Status word bit positions
    localparam int ST_N = 7;
    localparam int ST_V = 6;
    localparam int ST_ONE = 5;
    localparam int ST_B = 4;
    localparam int ST_D = 3;
    localparam int ST_I = 2;
    localparam int ST_Z = 1;
    localparam int ST_C = 0;

    // Values after reset
    localparam logic [7:0]  STAT_RST = 8'h34;
    localparam logic [7:0]  ACC_RST = 8'h00;
    localparam logic [15:0] PC_RST = 16'h0000;

    // Opcodes handled by this slice
    localparam logic [7:0] OP_ADC_IMM = 8'h69;
    localparam logic [7:0] OP_ADC_ABS = 8'h6D;
    localparam logic [7:0] OP_ADC_ZPI = 8'h72;
    localparam logic [7:0] OP_SHL_A = 8'h0A;
    localparam logic [7:0] OP_SHL_ZP = 8'h06;
    localparam logic [7:0] OP_SHL_ABS = 8'h0E;
    localparam logic [7:0] OP_BR_CC = 8'h90;
    localparam logic [7:0] OP_BR_CS = 8'hB0;
    localparam logic [3:0] OP_BBX_LO = 4'hF;

    typedef enum logic [2:0] {
        S_FETCH, S_OPND1, S_OPND2, S_IND_LO, S_IND_HI, S_READ, S_WRITE
    } ods_state_t;
endpackage

// >>> verilog/ods_alu.sv
// Purpose: Add-with-carry and left-shift datapath with flag results.
// Assumes: Binary mode only; decimal flag is not honoured.
// Notes:   Purely combinational, shared by accumulator and memory forms.
`timescale 1ns/1ns
module ods_alu
    import ods_pkg::*;
(
    input  wire logic       shift_i,
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] m_i,
    input  wire logic       c_i,
    output logic [7:0]      res_o,
    output logic            n_o,
    output logic            v_o,
    output logic            z_o,
    output logic            c_o
);
    logic [8:0] sum;

    // Nine-bit sum keeps the carry out
    assign sum = {1'b0, a_i} + {1'b0, m_i} + {8'h00, c_i};

    // Shift ignores a_i and the carry in
    always_comb begin
        if (shift_i) begin
            res_o = {m_i[6:0], 1'b0};
            c_o   = m_i[7];
            v_o   = 1'b0;
        end else begin
            res_o = sum[7:0];
            c_o   = sum[8];
            v_o   = (a_i[7] == m_i[7]) && (sum[7] != a_i[7]);
        end
        n_o = res_o[7];
        z_o = (res_o == 8'h00);
    end
endmodule

// >>> verilog/ods_core.sv
// Purpose: Decode and execute a slice of an 8-bit processor opcode map.
// Assumes: Memory answers on mclk_i; mem_ack_i is same-domain logic.
// Notes:   Unhandled opcodes act as one-byte no-operations.
`timescale 1ns/1ns
module ods_core
    import ods_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        reset_n_i,
    input  wire logic [7:0]  mem_rdata_i,
    input  wire logic        mem_ack_i,
    output logic             mem_req_o,
    output logic             mem_we_o,
    output logic [15:0]      mem_addr_o,
    output logic [7:0]       mem_wdata_o,
    output logic [7:0]       acc_o,
    output logic [7:0]       status_o,
    output logic [15:0]      pc_o
);
    logic        rst_meta_r;
    logic        rst_n_r;
    ods_state_t  state_r;
    logic [7:0]  op_r;
    logic [7:0]  b1_r;
    logic [7:0]  b2_r;
    logic [15:0] pc_r;
    logic [7:0]  acc_r;
    logic [7:0]  stat_r;
    logic        req_r;
    logic        we_r;
    logic [15:0] addr_r;
    logic [7:0]  wdata_r;
    logic        is_bbx;
    logic        is_shl_a;
    logic        adc_go;
    logic        shl_go;
    logic        bbx_go;
    logic        rel_go;
    logic        br_take;
    logic [15:0] br_base;
    logic [7:0]  br_disp;
    logic [15:0] br_tgt;
    logic [7:0]  alu_res;
    logic        alu_n;
    logic        alu_v;
    logic        alu_z;
    logic        alu_c;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r    <= rst_meta_r;
        end
    end

    // Decode helpers and execute strobes
    assign is_bbx   = (op_r[3:0] == OP_BBX_LO);
    assign is_shl_a = (state_r == S_FETCH) && (mem_rdata_i == OP_SHL_A);
    assign adc_go   = mem_ack_i && (((state_r == S_OPND1) && (op_r == OP_ADC_IMM)) ||
                      ((state_r == S_READ) && ((op_r == OP_ADC_ABS) ||
                      (op_r == OP_ADC_ZPI))));
    assign shl_go   = mem_ack_i && (is_shl_a || ((state_r == S_READ) &&
                      ((op_r == OP_SHL_ZP) || (op_r == OP_SHL_ABS))));
    assign bbx_go   = mem_ack_i && (state_r == S_READ) && is_bbx;
    assign rel_go   = mem_ack_i && (state_r == S_OPND1) &&
                      ((op_r == OP_BR_CC) || (op_r == OP_BR_CS));

    // Branch decision; the bit index is the low three bits of the opcode's high nibble
    always_comb begin
        if (state_r == S_READ) begin
            br_take = (mem_rdata_i[op_r[6:4]] == op_r[7]);
            br_base = pc_r;
            br_disp = b2_r;
        end else begin
            br_take = (stat_r[ST_C] == (op_r == OP_BR_CS));
            br_base = pc_r + 16'h0001;
            br_disp = mem_rdata_i;
        end
    end
    assign br_tgt = br_base + {{8{br_disp[7]}}, br_disp};

    ods_alu u_alu (
        .shift_i (shl_go),
        .a_i     (acc_r),
        .m_i     (is_shl_a ? acc_r : mem_rdata_i),
        .c_i     (stat_r[ST_C]),
        .res_o   (alu_res),
        .n_o     (alu_n),
        .v_o     (alu_v),
        .z_o     (alu_z),
        .c_o     (alu_c)
    );

    // Sequencer: each access holds until acknowledged, so stalls are free
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= S_FETCH;
            op_r    <= 8'h00;
            b1_r    <= 8'h00;
            b2_r    <= 8'h00;
            pc_r    <= PC_RST;
            req_r   <= 1'b0;
            we_r    <= 1'b0;
            addr_r  <= PC_RST;
            wdata_r <= 8'h00;
        end else if (!req_r) begin
            req_r <= 1'b1;
        end else if (mem_ack_i) begin
            case (state_r)
                S_FETCH: begin
                    op_r   <= mem_rdata_i;
                    pc_r   <= pc_r + 16'h0001;
                    addr_r <= pc_r + 16'h0001;
                    if ((mem_rdata_i == OP_ADC_IMM) || (mem_rdata_i == OP_ADC_ABS) ||
                        (mem_rdata_i == OP_ADC_ZPI) || (mem_rdata_i == OP_SHL_ZP) ||
                        (mem_rdata_i == OP_SHL_ABS) || (mem_rdata_i == OP_BR_CC) ||
                        (mem_rdata_i == OP_BR_CS) || (mem_rdata_i[3:0] == OP_BBX_LO)) begin
                        state_r <= S_OPND1;
                    end
                end
                S_OPND1: begin
                    b1_r    <= mem_rdata_i;
                    pc_r    <= pc_r + 16'h0001;
                    addr_r  <= pc_r + 16'h0001;
                    state_r <= S_FETCH;
                    if ((op_r == OP_SHL_ZP) || (op_r == OP_ADC_ZPI)) begin
                        addr_r  <= {8'h00, mem_rdata_i};
                        state_r <= (op_r == OP_ADC_ZPI) ? S_IND_LO : S_READ;
                    end else if ((op_r == OP_BR_CC) || (op_r == OP_BR_CS)) begin
                        if (br_take) begin
                            pc_r   <= br_tgt;
                            addr_r <= br_tgt;
                        end
                    end else if (op_r != OP_ADC_IMM) begin
                        state_r <= S_OPND2;
                    end
                end
                S_OPND2: begin
                    b2_r    <= mem_rdata_i;
                    pc_r    <= pc_r + 16'h0001;
                    addr_r  <= is_bbx ? {8'h00, b1_r} : {mem_rdata_i, b1_r};
                    state_r <= S_READ;
                end
                S_IND_LO: begin
                    b2_r    <= mem_rdata_i;
                    addr_r  <= {8'h00, b1_r + 8'h01}; // Pointer wraps in page zero
                    state_r <= S_IND_HI;
                end
                S_IND_HI: begin
                    addr_r  <= {mem_rdata_i, b2_r};
                    state_r <= S_READ;
                end
                S_READ: begin
                    state_r <= S_FETCH;
                    addr_r  <= pc_r;
                    if (shl_go) begin
                        we_r    <= 1'b1;
                        wdata_r <= alu_res;
                        addr_r  <= addr_r;
                        state_r <= S_WRITE;
                    end else if (is_bbx && br_take) begin
                        pc_r   <= br_tgt;
                        addr_r <= br_tgt;
                    end
                end
                default: begin
                    we_r    <= 1'b0;
                    addr_r  <= pc_r;
                    state_r <= S_FETCH;
                end
            endcase
        end
    end

    // Accumulator takes sums and accumulator shifts only
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            acc_r <= ACC_RST;
        end else if (adc_go || (shl_go && is_shl_a)) begin
            acc_r <= alu_res;
        end
    end

    // Status word; branches never reach here, bit 5 is pinned high
    always_ff @(posedge mclk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            stat_r <= STAT_RST;
        end else begin
            if (adc_go || shl_go) begin
                stat_r[ST_N] <= alu_n;
                stat_r[ST_Z] <= alu_z;
                stat_r[ST_C] <= alu_c;
            end
            if (adc_go) begin
                stat_r[ST_V] <= alu_v;
            end
            stat_r[ST_ONE] <= 1'b1;
        end
    end

    assign mem_req_o   = req_r;
    assign mem_we_o    = we_r;
    assign mem_addr_o  = addr_r;
    assign mem_wdata_o = wdata_r;
    assign acc_o       = acc_r;
    assign status_o    = stat_r;
    assign pc_o        = pc_r;

    // Checks on the execute behaviour
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_r);

    a_stat_one_bit: assert property (stat_r[ST_ONE] && $stable(stat_r[ST_B]))
        else $error("status bit 5 or break bit disturbed");
    a_adc_sum_ok: assert property (adc_go |=> acc_r == 8'($past(acc_r) +
        $past(mem_rdata_i) + {7'h00, $past(stat_r[ST_C])}))
        else $error("add with carry result wrong");
    a_shl_mem_ok: assert property ((shl_go && !is_shl_a) |=> we_r &&
        (wdata_r == {$past(mem_rdata_i[6:0]), 1'b0}) && (stat_r[ST_C] == $past(mem_rdata_i[7])))
        else $error("memory shift result wrong");
    a_bit_clr_take: assert property ((bbx_go && !op_r[7] && !mem_rdata_i[op_r[6:4]]) |=>
        pc_r == $past(pc_r) + {{8{$past(b2_r[7])}}, $past(b2_r)})
        else $error("bit clear branch not taken");
    a_bbx_flags_keep: assert property (bbx_go |=> $stable(stat_r) ##1 1'b1)
        else $error("bit branch altered flags");
    a_bit_set_fall: assert property ((bbx_go && op_r[7] && !mem_rdata_i[op_r[6:4]]) |=>
        pc_r == $past(pc_r) && state_r == S_FETCH)
        else $error("bit set branch taken wrongly");
    a_cclr_fall: assert property ((rel_go && op_r == OP_BR_CC && stat_r[ST_C]) |=>
        pc_r == $past(pc_r) + 16'h0001 && $stable(stat_r))
        else $error("carry clear branch misbehaved");
    a_cset_taken: assert property ((rel_go && op_r == OP_BR_CS && stat_r[ST_C]) |=>
        pc_r == $past(pc_r) + 16'h0001 + {{8{$past(mem_rdata_i[7])}}, $past(mem_rdata_i)})
        else $error("carry set branch target wrong");
    a_stall_keeps: assert property ((req_r && !mem_ack_i) |=> $stable(acc_r) &&
        $stable(stat_r) && $stable(pc_r) && $stable(addr_r))
        else $error("state changed during stall");

    c_adc_done: cover property (adc_go ##1 state_r == S_FETCH);
    c_bit_set_take: cover property (bbx_go && op_r[7] && br_take);
    c_shl_write: cover property (state_r == S_WRITE && mem_ack_i);
    c_cclr_taken: cover property (rel_go && op_r == OP_BR_CC && br_take);
endmodule

// >>> test/ods_mem_model.sv
// Purpose: Memory behind the core's request/acknowledge port.
// Assumes: Ack is same-clock; wait_i sets wait cycles per access.
// Notes:   Unwritten bytes read as EA, an unhandled opcode.
`timescale 1ns/1ns
module ods_mem_model (
    input  wire logic        mclk_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    input  wire logic [1:0]  wait_i,
    output logic             mem_ack_o,
    output logic [7:0]       mem_rdata_o
);
    logic [7:0] mem [0:65535];
    logic [1:0] cnt_r;
    logic [7:0] last_r;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hEA;
        end
        cnt_r = 2'h0;
        last_r = 8'h00;
    end

    // Ack only after the chosen wait; stretched accesses keep state
    assign mem_ack_o = mem_req_i && (cnt_r == wait_i);
    // Idle data shows the inverse of the last byte, never a stale match
    assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i] : ~last_r;

    // Wait counter, last-value holder and write port
    always @(posedge mclk_i) begin
        if (mem_ack_o) begin
            cnt_r <= 2'h0;
            last_r <= mem_rdata_o;
            if (mem_we_i) begin
                mem[mem_addr_i] <= mem_wdata_i;
            end
        end else if (mem_req_i) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
endmodule

// >>> test/ods_core_bench.sv
// Purpose: Runs one program through the core and checks A, status, pc.
// Assumes: Program is loaded before reset; starts at 0000.
// Notes:   Clock is stopped once mid-run to show static behaviour.
`timescale 1ns/1ns
module ods_core_bench;
    import ods_pkg::*;
    logic        mclk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        clk_stop = 1'b0;
    logic [1:0]  wait_i = 2'h0;
    logic [7:0]  mem_rdata_i;
    logic        mem_ack_i;
    logic        mem_req_o;
    logic        mem_we_o;
    logic [15:0] mem_addr_o;
    logic [7:0]  mem_wdata_o;
    logic [7:0]  acc_o;
    logic [7:0]  status_o;
    logic [15:0] pc_o;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;
    // Program image, then expected A and status at each fetch address
    logic [7:0]  prog [0:46] = '{8'h69, 8'h7F, 8'h69, 8'h01, 8'h0A, 8'h90, 8'h10, 8'hB0,
        8'h05, 8'hEA, 8'hEA, 8'hEA, 8'hEA, 8'hEA, 8'h6D, 8'h00, 8'h02, 8'h90, 8'h02,
        8'h69, 8'h55, 8'h06, 8'h40, 8'h72, 8'h42, 8'h0F, 8'h40, 8'h05, 8'hEA, 8'hEA,
        8'hEA, 8'hEA, 8'hEA, 8'h9F, 8'h40, 8'h03, 8'hEA, 8'hEA, 8'hEA, 8'h8F, 8'h40,
        8'hF0, 8'h0E, 8'h00, 8'h02, 8'hB0, 8'h80};
    logic [15:0] ex_pc [0:13] = '{16'h0002, 16'h0004, 16'h0005, 16'h0007, 16'h000E,
        16'h0011, 16'h0015, 16'h0017, 16'h0019, 16'h0021, 16'h0027, 16'h002A,
        16'h002D, 16'hFFAF};
    logic [7:0]  ex_a [0:13] = '{8'h7F, 8'h80, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF,
        8'hFF, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0]  ex_s [0:13] = '{8'h34, 8'hF4, 8'h77, 8'h77, 8'h77, 8'hB4, 8'hB4,
        8'h35, 8'h35, 8'h35, 8'h35, 8'h35, 8'hB5, 8'hB5};

    ods_core i_ods_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .mem_rdata_i(mem_rdata_i),
        .mem_ack_i(mem_ack_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .acc_o(acc_o),
        .status_o(status_o), .pc_o(pc_o));
    ods_mem_model i_ods_mem_model (.mclk_i(mclk_i), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
        .wait_i(wait_i), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

    // Clock; gating it models a stopped input clock
    initial begin
        forever begin
            #10;
            if (!clk_stop) begin
                mclk_i = ~mclk_i;
            end
        end
    end

    task automatic finish_test();
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input int idx);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t check %0d: got %h expected %h", $time, idx, got, exp);
        end
    endtask

    // Waits for the core to put address a on the port, bounded
    task automatic wait_addr(input logic [15:0] a);
        int k;
        for (k = 0; k < 200; k++) begin
            @(posedge mclk_i);
            #1;
            if (mem_addr_o === a && mem_req_o === 1'b1) begin
                break;
            end
        end
        if (k == 200) begin
            err_total++;
            $display("[ERR] %0t address %h never reached", $time, a);
        end
    endtask

    // Hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            $display("[ERR] %0t run did not finish", $time);
            finish_test();
        end
    end

    initial begin
        // Load after the model's own fill at time zero, or the fill may win
        #1;
        for (int i = 0; i < 47; i++) begin
            i_ods_mem_model.mem[i] = prog[i];
        end
        i_ods_mem_model.mem[16'h0040] = 8'h81;
        i_ods_mem_model.mem[16'h0042] = 8'h00;
        i_ods_mem_model.mem[16'h0043] = 8'h03;
        i_ods_mem_model.mem[16'h0200] = 8'hFE;
        i_ods_mem_model.mem[16'h0300] = 8'h01;
        repeat (3) @(posedge mclk_i);
        #2;
        check8(status_o, STAT_RST, 100);
        check8(acc_o, ACC_RST, 101);
        check8({7'h00, mem_req_o}, 8'h00, 102);
        check8(pc_o[7:0], PC_RST[7:0], 103);
        reset_n_i = 1'b1;
        for (int i = 0; i < 14; i++) begin
            wait_addr(ex_pc[i]);
            check8(acc_o, ex_a[i], i);
            check8(status_o, ex_s[i], 20 + i);
            if (i == 5) begin
                #1;
                wait_i = 2'h2;
                clk_stop = 1'b1;
                #3000;
                clk_stop = 1'b0;
            end
        end
        check8(pc_o[15:8], 8'hFF, 40);
        check8(i_ods_mem_model.mem[16'h0040], 8'h02, 41);
        check8(i_ods_mem_model.mem[16'h0200], 8'hFC, 42);
        finish_test();
    end
endmodule
